// *** logic/registered_bus_xcvr.sv ***
// registered two-way transceiver between a card port and a backplane port
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_cfg.svh"

module registered_bus_xcvr #(
  parameter int WIDTH = `XCVR_WIDTH,
  parameter int HALF_WIDTH = `XCVR_HALF_WIDTH
) (
  input wire logic mclk_i, // 25 MHz system clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic fwd_clock_i, // card-to-backplane storage clock
  input wire logic rev_clock_i, // backplane-to-card storage clock
  input wire logic fwd_clock_enable_n_i, // forward capture enable, low
  input wire logic rev_clock_enable_n_i, // reverse capture enable, low
  input wire xcvr_pkg::oe_pair_t fwd_output_enable_n_i, // per half, low
  input wire xcvr_pkg::oe_pair_t rev_output_enable_n_i, // per half, low
  input wire xcvr_pkg::word_t card_i, // card-side pin level
  output logic [WIDTH-1:0] card_o, // card-side drive value
  output logic [WIDTH-1:0] card_oe_n_o, // card-side drive, low drives
  input wire xcvr_pkg::word_t bp_i, // backplane-side pin level
  output logic [WIDTH-1:0] bp_o, // backplane drive value
  output logic [WIDTH-1:0] bp_oe_n_o // backplane drive, low drives
);
  import xcvr_pkg::*;

  // ----------------------------------------------------------------
  // clock pin edge detection
  // ----------------------------------------------------------------
  // the storage clocks are pins sampled on mclk, so a rise is seen
  // as a high sample after a low one; pulses shorter than 40 ns can be missed
  // a clock pin already high at reset release counts as a rise,
  // since the history restarts low
  logic fwd_clk_prev_q;
  logic rev_clk_prev_q;
  wire fwd_rise = fwd_clock_i & ~fwd_clk_prev_q;
  wire rev_rise = rev_clock_i & ~rev_clk_prev_q;
  wire fwd_load = fwd_rise & ~fwd_clock_enable_n_i;
  wire rev_load = rev_rise & ~rev_clock_enable_n_i;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fwd_clk_prev_q <= `XCVR_CLK_RST;
      rev_clk_prev_q <= `XCVR_CLK_RST;
    end else begin
      fwd_clk_prev_q <= fwd_clock_i;
      rev_clk_prev_q <= rev_clock_i;
    end
  end

  // ----------------------------------------------------------------
  // storage flip-flops
  // ----------------------------------------------------------------
  // reset value is only a tidy start; contents count as garbage
  // until the first qualified rise in each direction
  // both directions may load in one mclk cycle; they share no flops,
  // so a forward capture never touches the reverse word
  logic [WIDTH-1:0] fwd_data_q;
  logic [WIDTH-1:0] rev_data_q;
  logic [WIDTH-1:0] fwd_data_d;
  logic [WIDTH-1:0] rev_data_d;
  assign fwd_data_d = fwd_load ? card_i : fwd_data_q;
  assign rev_data_d = rev_load ? bp_i : rev_data_q;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fwd_data_q <= `XCVR_DATA_RST;
      rev_data_q <= `XCVR_DATA_RST;
    end else begin
      fwd_data_q <= fwd_data_d;
      rev_data_q <= rev_data_d;
    end
  end

  assign bp_o = fwd_data_q;
  assign card_o = rev_data_q;

  // ----------------------------------------------------------------
  // per-half output enables
  // ----------------------------------------------------------------
  // registered so every pin control leaves straight from a flip-flop;
  // costs one mclk of enable latency
  // a half follows only its own enable bit; nothing in the data path
  // can pull its pins out of isolation
  genvar h;
  generate
    for (h = 0; h < `XCVR_HALVES; h++) begin : g_half
      logic fwd_oe_n_q;
      logic rev_oe_n_q;
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          fwd_oe_n_q <= `XCVR_OE_N_RST;
          rev_oe_n_q <= `XCVR_OE_N_RST;
        end else begin
          fwd_oe_n_q <= fwd_output_enable_n_i[h];
          rev_oe_n_q <= rev_output_enable_n_i[h];
        end
      end
      assign bp_oe_n_o[h*HALF_WIDTH +: HALF_WIDTH] = {HALF_WIDTH{fwd_oe_n_q}};
      assign card_oe_n_o[h*HALF_WIDTH +: HALF_WIDTH] =
        {HALF_WIDTH{rev_oe_n_q}};

      chk_fwd_half_oe: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        ##1 bp_oe_n_o[h*HALF_WIDTH +: HALF_WIDTH] ==
          {HALF_WIDTH{$past(fwd_output_enable_n_i[h])}})
        else $error("forward half enable not followed");
      chk_rev_half_oe: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        ##1 card_oe_n_o[h*HALF_WIDTH +: HALF_WIDTH] ==
          {HALF_WIDTH{$past(rev_output_enable_n_i[h])}})
        else $error("reverse half enable not followed");

      chk_fwd_half_alone: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        $stable(fwd_output_enable_n_i[h])
          |=> $stable(bp_oe_n_o[h*HALF_WIDTH +: HALF_WIDTH]))
        else $error("forward half moved without its own enable change");
      chk_rev_half_alone: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        $stable(rev_output_enable_n_i[h])
          |=> $stable(card_oe_n_o[h*HALF_WIDTH +: HALF_WIDTH]))
        else $error("reverse half moved without its own enable change");
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_fwd_clocked_copy: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    (fwd_clock_i && !fwd_clk_prev_q && !fwd_clock_enable_n_i)
      |=> bp_o == $past(card_i))
    else $error("forward capture did not copy card data");
  chk_rev_clocked_copy: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    (rev_clock_i && !rev_clk_prev_q && !rev_clock_enable_n_i)
      |=> card_o == $past(bp_i))
    else $error("reverse capture did not copy backplane data");
  chk_fwd_ce_hold: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    fwd_clock_enable_n_i |=> $stable(bp_o))
    else $error("forward data moved with capture disabled");
  chk_fwd_static_clk: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    ($stable(fwd_clock_i) && fwd_clk_prev_q == fwd_clock_i)
      |=> $stable(bp_o))
    else $error("forward data moved with clock static");
  chk_rev_ce_hold: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    rev_clock_enable_n_i |=> $stable(card_o))
    else $error("reverse data moved with capture disabled");
  chk_all_bits_gated: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    (fwd_clock_enable_n_i && $changed(card_i)) ##1 fwd_clock_enable_n_i
      |=> $stable(bp_o))
    else $error("part of forward word loaded with capture disabled");
  chk_fwd_no_fall_load: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    (!fwd_clock_i && fwd_clk_prev_q) |=> $stable(bp_o))
    else $error("forward storage loaded on falling clock");

  // ----------------------------------------------------------------
  // reverse direction checks
  // ----------------------------------------------------------------
  // mirror of the forward hold checks; each direction owns its flops
  chk_rev_static_clk: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    ($stable(rev_clock_i) && rev_clk_prev_q == rev_clock_i)
      |=> $stable(card_o))
    else $error("reverse data moved with clock static");
  chk_rev_no_fall_load: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    (!rev_clock_i && rev_clk_prev_q) |=> $stable(card_o))
    else $error("reverse storage loaded on falling clock");
  chk_rev_bits_gated: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    (rev_clock_enable_n_i && $changed(bp_i)) ##1 rev_clock_enable_n_i
      |=> $stable(card_o))
    else $error("part of reverse word loaded with capture disabled");
  // a forward-only load must leave the reverse direction's word alone
  chk_fwd_leaves_rev: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    (fwd_load && !rev_load) |=> $stable(card_o))
    else $error("forward capture disturbed reverse storage");

  // ----------------------------------------------------------------
  // isolation while reset is held
  // ----------------------------------------------------------------
  // no disable here: every pin must float for the whole reset; the
  // first reset edge is skipped, as the flops settle only on it
  chk_reset_floats: assert property (@(posedge mclk_i)
    (!rst_b_i ##1 !rst_b_i) |-> (&bp_oe_n_o && &card_oe_n_o))
    else $error("a pin was driven while reset was held");

  // ----------------------------------------------------------------
  // coverage of the main scenarios
  // ----------------------------------------------------------------

  cov_fwd_capture: cover property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    fwd_load ##1 bp_oe_n_o == {WIDTH{1'h0}});
  cov_rev_capture: cover property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    rev_load ##1 card_oe_n_o == {WIDTH{1'h0}});
  cov_split_halves: cover property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    fwd_output_enable_n_i == 2'h1 ##1 fwd_output_enable_n_i == 2'h2);
  cov_blocked_rise: cover property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    fwd_rise && fwd_clock_enable_n_i);
  cov_rev_blocked_rise: cover property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    rev_rise && rev_clock_enable_n_i);
endmodule : registered_bus_xcvr
`default_nettype wire

// *** logic/xcvr_cfg.svh ***
// constants for the registered bus transceiver
`ifndef XCVR_CFG_SVH
`define XCVR_CFG_SVH

// ------------------------------------------------------------------
// data organisation
// ------------------------------------------------------------------
`define XCVR_WIDTH 18
`define XCVR_HALVES 2
`define XCVR_HALF_WIDTH 9

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define XCVR_DATA_RST 18'h00000
`define XCVR_OE_N_RST 1'h1
`define XCVR_CLK_RST 1'h0

`endif

// *** logic/xcvr_pkg.sv ***
// types shared by the registered bus transceiver
`default_nettype none
`include "xcvr_cfg.svh"

package xcvr_pkg;
  typedef logic [`XCVR_WIDTH-1:0] word_t;
  typedef logic [`XCVR_HALVES-1:0] oe_pair_t;
endpackage : xcvr_pkg
`default_nettype wire

// *** tb/far_side_model.sv ***
// far side: card logic and backplane bus sharing the pins
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input wire xcvr_pkg::word_t card_drv_i, // card logic value
  input wire xcvr_pkg::word_t bp_drv_i, // backplane value
  input wire xcvr_pkg::word_t card_o_i, // device card drive
  input wire xcvr_pkg::word_t card_oe_n_i, // low: device drives
  input wire xcvr_pkg::word_t bp_o_i, // device bp drive
  input wire xcvr_pkg::word_t bp_oe_n_i, // low: device drives
  output logic [17:0] card_pin_o, // resolved card pins
  output logic [17:0] bp_pin_o // resolved bp pins
);
  import xcvr_pkg::*;
  // far side backs off wherever the device drives, so no contention
  assign card_pin_o = (card_oe_n_i & card_drv_i) | (~card_oe_n_i & card_o_i);
  assign bp_pin_o = (bp_oe_n_i & bp_drv_i) | (~bp_oe_n_i & bp_o_i);
endmodule : far_side_model
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the registered bus transceiver
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_cfg.svh"
module tb_top;
  import xcvr_pkg::*;
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  logic fclk = 1'h0, rclk = 1'h0, fce_n = 1'h1, rce_n = 1'h1;
  oe_pair_t foe_n = 2'h3, roe_n = 2'h3;
  word_t cdrv = 18'h00000, bdrv = 18'h00000;
  word_t cpin, bpin, co, coe, bo, boe, fexp, rexp;
  int mismatches = 0, tests_run = 0;
  logic [31:0] seed = 32'h0000_4F53;
  always #20 mclk = ~mclk;
  registered_bus_xcvr registered_bus_xcvr_inst (.mclk_i(mclk),
    .rst_b_i(rst_b), .fwd_clock_i(fclk), .rev_clock_i(rclk),
    .fwd_clock_enable_n_i(fce_n), .rev_clock_enable_n_i(rce_n),
    .fwd_output_enable_n_i(foe_n), .rev_output_enable_n_i(roe_n),
    .card_i(cpin), .card_o(co), .card_oe_n_o(coe), .bp_i(bpin),
    .bp_o(bo), .bp_oe_n_o(boe));
  far_side_model far_side_model_inst (.card_drv_i(cdrv), .bp_drv_i(bdrv),
    .card_o_i(co), .card_oe_n_i(coe), .bp_o_i(bo), .bp_oe_n_i(boe),
    .card_pin_o(cpin), .bp_pin_o(bpin));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : nxt
  function automatic word_t oe_map(input oe_pair_t o);
    return {{`XCVR_HALF_WIDTH{o[1]}}, {`XCVR_HALF_WIDTH{o[0]}}};
  endfunction : oe_map
  // pin level: far side where the device floats, device word elsewhere
  function automatic word_t mix(input oe_pair_t o, input word_t drv,
    input word_t dev);
    return (oe_map(o) & drv) | (~oe_map(o) & dev);
  endfunction : mix
  task automatic chk(input word_t got, input word_t exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  // one rise in a direction, then a held high clock and a fall
  task automatic step(input bit fwd, input bit first);
    word_t d;
    logic ce_n;
    oe_pair_t oe;
    seed = nxt(seed);
    d = seed[17:0];
    ce_n = first ? 1'h0 : seed[20];
    oe = first ? 2'h3 : seed[23:22];
    @(negedge mclk);
    if (fwd) begin
      {fclk, fce_n, foe_n, cdrv} = {1'h1, ce_n, oe, d};
      if (!ce_n) fexp = mix(roe_n, d, rexp);
    end else begin
      {rclk, rce_n, roe_n, bdrv} = {1'h1, ce_n, oe, d};
      if (!ce_n) rexp = mix(foe_n, d, fexp);
    end
    @(negedge mclk);
    chk(fwd ? bo : co, fwd ? fexp : rexp);
    chk(fwd ? boe : coe, oe_map(oe));
    seed = nxt(seed);
    {cdrv, bdrv, fce_n, rce_n} = {seed[17:0], ~seed[17:0], 2'h0};
    @(negedge mclk);
    {fclk, rclk} = 2'h0;
    @(negedge mclk);
    chk(fwd ? bo : co, fwd ? fexp : rexp);
  endtask : step
  initial begin
    repeat (6) @(negedge mclk);
    rst_b = 1'h1;
    step(1'h1, 1'h1);
    step(1'h0, 1'h1);
    repeat (300) begin
      seed = nxt(seed);
      step(seed[4], 1'h0);
    end
    report_and_stop();
  end
  // ~1214 cycles expected; cut off well beyond
  initial begin
    #(40 * 3000);
    mismatches++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
